// ==== gdc_top.sv ====
`include "gdc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module gdc_top
	import gdc_pkg::*;
#(
	parameter int CNT_W    = 8,               // dead time counter width
	parameter int DEAD_CYC = `GDC_DEAD_CYC    // fixed dead time in cycles
) (
	input  wire logic                   clk_i,                  // system clock
	input  wire logic                   rst_i,                  // async reset, high
	input  wire logic                   enable_i,               // shared enable pin
	input  wire logic                   enable_drive_i,         // enable pin is driven
	input  wire logic [`GDC_NCH-1:0]    high_side_command_i,    // high side commands
	input  wire logic [`GDC_NCH-1:0]    high_drive_i,           // high command pins driven
	input  wire logic [`GDC_NCH-1:0]    low_side_command_n_i,   // low side commands, low active
	input  wire logic [`GDC_NCH-1:0]    low_drive_i,            // low command pins driven
	input  wire gdc_cmp_t               supply_cmp_i,           // supply comparators
	input  wire gdc_cmp_t [`GDC_NCH-1:0] bootstrap_cmp_i,       // bootstrap comparators
	input  wire gdc_cmp_t               gate_supply_cmp_i,      // 12 V supply comparators
	input  wire gdc_cmp_t               logic_supply_cmp_i,     // 5 V supply comparators
	input  wire gdc_cmp_t               temp_cmp_i,             // shutdown / recovery temp
	output logic [`GDC_NCH-1:0]         high_gate_out_o,        // high side gates
	output logic [`GDC_NCH-1:0]         low_gate_out_o,         // low side gates
	output logic                        bootstrap_charge_en_o,  // bootstrap charging allowed
	output logic                        gate_supply_en_o,       // 12 V gate supply on
	output logic                        irq_o,                  // level interrupt
	input  wire logic [3:0]             s_axi_awaddr,           // write address
	input  wire logic                   s_axi_awvalid,          // write address valid
	output logic                        s_axi_awready,          // write address ready
	input  wire logic [31:0]            s_axi_wdata,            // write data
	input  wire logic [3:0]             s_axi_wstrb,            // write strobes
	input  wire logic                   s_axi_wvalid,           // write data valid
	output logic                        s_axi_wready,           // write data ready
	output logic [1:0]                  s_axi_bresp,            // write response
	output logic                        s_axi_bvalid,           // write response valid
	input  wire logic                   s_axi_bready,           // write response ready
	input  wire logic [3:0]             s_axi_araddr,           // read address
	input  wire logic                   s_axi_arvalid,          // read address valid
	output logic                        s_axi_arready,          // read address ready
	output logic [31:0]                 s_axi_rdata,            // read data
	output logic [1:0]                  s_axi_rresp,            // read response
	output logic                        s_axi_rvalid,           // read response valid
	input  wire logic                   s_axi_rready            // read response ready
);

	localparam int SW = 1 + 2 * `GDC_NCH + 2 * `GDC_NLOCK;  // synchronised width

	// command pair to wanted side, truth table of the driver
	function automatic gdc_side_t want_side(input logic en, input gdc_cmd_t c);
		gdc_side_t s;
		s = GDC_SIDE_NONE;
		if (en && c.high_side_command && c.low_side_command_n) begin
			s = GDC_SIDE_HIGH;
		end else if (en && !c.high_side_command && !c.low_side_command_n) begin
			s = GDC_SIDE_LOW;
		end
		return s;
	endfunction

	// hysteresis latch: set below lower, clear at upper; set wins
	function automatic logic hyst(input logic cur, input gdc_cmp_t c);
		logic n;
		n = cur;
		if (c.below_low) begin
			n = 1'b1;
		end else if (c.above_high) begin
			n = 1'b0;
		end
		return n;
	endfunction

	logic [`GDC_NCH-1:0]   hi_res;       // high command after pull resolution
	logic [`GDC_NCH-1:0]   lo_res;       // low command after pull resolution
	logic                  en_res;       // enable after pull resolution
	logic [SW-1:0]         raw_vec;      // pin vector before synchroniser
	logic [SW-1:0]         sync_a;       // first synchroniser stage
	logic [SW-1:0]         sync_b;       // second synchroniser stage
	logic                  en_s;         // synchronised enable
	gdc_cmd_t [`GDC_NCH-1:0] cmd_s;      // synchronised commands
	gdc_cmp_t [`GDC_NLOCK-1:0] cmp_s;    // synchronised comparators
	logic [`GDC_NLOCK-1:0] lock;         // active lockouts
	logic [`GDC_NLOCK-1:0] lock_q;       // lockouts one cycle ago
	logic                  sw_enable;    // software drive enable
	logic [`GDC_NLOCK-1:0] irq_stat;     // sticky lockout events
	logic [`GDC_NLOCK-1:0] irq_mask;     // interrupt mask
	logic                  block_all;    // both sides of every channel off
	logic [CNT_W-1:0]      dead_cnt [`GDC_NCH];  // dead time counters
	gdc_side_t             last_side [`GDC_NCH]; // side that last conducted

	// internal pulls: undriven enable/high read 0, undriven low_n reads 1
	always_comb begin
		en_res = enable_drive_i & enable_i;
		for (int i = 0; i < `GDC_NCH; i++) begin
			hi_res[i] = high_drive_i[i] & high_side_command_i[i];
			lo_res[i] = ~low_drive_i[i] | low_side_command_n_i[i];
		end
	end

	// gather all asynchronous inputs into one vector
	// one vector keeps every pin behind the same two stages, so none leads
	assign raw_vec = {temp_cmp_i, logic_supply_cmp_i, gate_supply_cmp_i,
		bootstrap_cmp_i, supply_cmp_i, lo_res, hi_res, en_res};

	// two flip-flop synchroniser; stage a feeds stage b only
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= raw_vec;
			sync_b <= sync_a;
		end
	end

	// unpack synchronised vector
	always_comb begin
		en_s = sync_b[0];
		for (int i = 0; i < `GDC_NCH; i++) begin
			cmd_s[i].high_side_command  = sync_b[1 + i];
			cmd_s[i].low_side_command_n = sync_b[1 + `GDC_NCH + i];
		end
		for (int k = 0; k < `GDC_NLOCK; k++) begin
			cmp_s[k] = sync_b[1 + 2 * `GDC_NCH + 2 * k +: 2];
		end
	end

	// lockout latches; reset assumes everything locked until proven good
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock <= '1;
		end else begin
			for (int k = 0; k < `GDC_NLOCK; k++) begin
				lock[k] <= hyst(lock[k], cmp_s[k]);
			end
		end
	end

	// a lost main or 5 V supply, or a hot die, leaves neither side safely driven
	// locks that shut every gate of every channel
	assign block_all = lock[`GDC_LK_SUPPLY] | lock[`GDC_LK_LOGIC] | lock[`GDC_LK_OTP];

	// bootstrap charging off for all but bootstrap lock
	assign bootstrap_charge_en_o = ~(block_all | lock[`GDC_LK_GATE]);

	// 12 V gate supply off only during supply lock
	assign gate_supply_en_o = ~lock[`GDC_LK_SUPPLY];

	// per channel gate sequencing with dead time
	for (genvar g = 0; g < `GDC_NCH; g++) begin : g_ch
		gdc_side_t want;   // commanded side
		logic      ok_hi;  // high side allowed by protections
		logic      ok_lo;  // low side allowed by protections
		logic      req_hi; // high gate requested
		logic      req_lo; // low gate requested

		// protections mask each side separately
		always_comb begin
			want   = want_side(en_s & sw_enable, cmd_s[g]);
			ok_hi  = ~block_all & ~lock[`GDC_LK_BST0 + g];
			ok_lo  = ~block_all & ~lock[`GDC_LK_GATE];
			req_hi = (want == GDC_SIDE_HIGH) & ok_hi;
			req_lo = (want == GDC_SIDE_LOW) & ok_lo;
		end

		// a turn-off by protection loads the gap too, so recovery cannot shoot through
		// gates turn off at once; opposite side waits out the counter
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				high_gate_out_o[g] <= 1'b0;
				low_gate_out_o[g]  <= 1'b0;
				dead_cnt[g]        <= '0;
				last_side[g]       <= GDC_SIDE_NONE;
			end else if (high_gate_out_o[g] && !req_hi) begin
				// high side leaves: start the gap
				high_gate_out_o[g] <= 1'b0;
				dead_cnt[g]        <= CNT_W'(DEAD_CYC);
				last_side[g]       <= GDC_SIDE_HIGH;
			end else if (low_gate_out_o[g] && !req_lo) begin
				// low side leaves: start the gap
				low_gate_out_o[g] <= 1'b0;
				dead_cnt[g]       <= CNT_W'(DEAD_CYC);
				last_side[g]      <= GDC_SIDE_LOW;
			end else if (dead_cnt[g] != '0) begin
				// during the gap only the side that just left may return
				dead_cnt[g] <= dead_cnt[g] - CNT_W'(1);
				if (req_hi && last_side[g] == GDC_SIDE_HIGH) begin
					high_gate_out_o[g] <= 1'b1;
				end
				if (req_lo && last_side[g] == GDC_SIDE_LOW) begin
					low_gate_out_o[g] <= 1'b1;
				end
			end else begin
				// gap over: follow the request; req_hi, req_lo exclusive
				high_gate_out_o[g] <= req_hi;
				low_gate_out_o[g]  <= req_lo;
			end
		end
	end

	// register bus: enable, status, flags and mask on four words
	logic       aw_held;    // write address captured
	logic [3:0] aw_addr;    // captured write address
	logic       w_held;     // write data captured
	logic [31:0] w_data;    // captured write data
	logic [3:0] w_strb;     // captured strobes
	logic       do_write;   // both halves present, commit now
	logic [`GDC_NLOCK-1:0] clr_bits;  // write-one-to-clear pattern
	logic [31:0] next_rdata;          // read mux output
	logic        next_rerr;           // read decode miss

	// ready drops while a half waits or a response stands: one write at a time
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write      = aw_held & w_held & ~s_axi_bvalid;

	// capture address and data in either order
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	// write data holding register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// write response, error on unmapped address
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `GDC_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr)
				`GDC_REG_CTRL, `GDC_REG_STATUS, `GDC_REG_IRQ_STAT,
				`GDC_REG_IRQ_MASK: s_axi_bresp <= `GDC_RESP_OKAY;
				default:           s_axi_bresp <= `GDC_RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control and mask registers; fields sit in byte lane 0
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sw_enable <= `GDC_CTRL_RST;
			irq_mask  <= `GDC_MASK_RST;
		end else if (do_write && w_strb[0]) begin
			if (aw_addr == `GDC_REG_CTRL) begin
				sw_enable <= w_data[`GDC_CTRL_EN_BIT];
			end
			if (aw_addr == `GDC_REG_IRQ_MASK) begin
				irq_mask <= w_data[`GDC_NLOCK-1:0];
			end
		end
	end

	// write-one-to-clear pattern, taken from byte lane 0 only
	assign clr_bits = (do_write && w_strb[0] && aw_addr == `GDC_REG_IRQ_STAT) ?
		w_data[`GDC_NLOCK-1:0] : '0;

	// sticky events on lock entry; a new entry beats a same-cycle clear
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			lock_q   <= '1;
			irq_stat <= '0;
		end else begin
			lock_q   <= lock;
			irq_stat <= (irq_stat & ~clr_bits) | (lock & ~lock_q);
		end
	end

	// level interrupt while any unmasked flag stands
	assign irq_o = |(irq_stat & irq_mask);

	// read decode; unused bits read zero
	always_comb begin
		next_rdata = '0;
		next_rerr  = 1'b0;
		case (s_axi_araddr)
			`GDC_REG_CTRL:     next_rdata[`GDC_CTRL_EN_BIT] = sw_enable;
			`GDC_REG_STATUS: begin
				next_rdata[`GDC_ST_LOCK_LSB +: `GDC_NLOCK] = lock;
				next_rdata[`GDC_ST_HIGH_LSB +: `GDC_NCH]   = high_gate_out_o;
				next_rdata[`GDC_ST_LOW_LSB +: `GDC_NCH]    = low_gate_out_o;
			end
			`GDC_REG_IRQ_STAT: next_rdata[`GDC_NLOCK-1:0] = irq_stat;
			`GDC_REG_IRQ_MASK: next_rdata[`GDC_NLOCK-1:0] = irq_mask;
			default:           next_rerr = 1'b1;
		endcase
	end

	// read response registered, held until rready
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `GDC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= next_rdata;
			s_axi_rresp  <= next_rerr ? `GDC_RESP_SLVERR : `GDC_RESP_OKAY;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule // gdc_top
`default_nettype wire

// ==== gdc_params.svh ====
`ifndef GDC_PARAMS_SVH
`define GDC_PARAMS_SVH

// system clock rate in MHz
`define GDC_CLK_MHZ         25
// fixed dead time in ns
`define GDC_DEAD_NS         400
// fixed dead time in cycles, rounded up to whole cycles
`define GDC_DEAD_CYC        ((`GDC_DEAD_NS * `GDC_CLK_MHZ + 999) / 1000)

// number of half-bridge channels
`define GDC_NCH             3
// number of lockout conditions
`define GDC_NLOCK           7

// lockout bit positions
`define GDC_LK_SUPPLY       0
`define GDC_LK_BST0         1
`define GDC_LK_GATE         4
`define GDC_LK_LOGIC        5
`define GDC_LK_OTP          6

// register byte offsets
`define GDC_REG_CTRL        4'h0
`define GDC_REG_STATUS      4'h4
`define GDC_REG_IRQ_STAT    4'h8
`define GDC_REG_IRQ_MASK    4'hC

// control register field, control and mask resets
`define GDC_CTRL_EN_BIT     0
`define GDC_CTRL_RST        1'b1
`define GDC_MASK_RST        7'h00

// status register field positions
`define GDC_ST_LOCK_LSB     0
`define GDC_ST_HIGH_LSB     7
`define GDC_ST_LOW_LSB      10

// bus response codes
`define GDC_RESP_OKAY       2'h0
`define GDC_RESP_SLVERR     2'h2

`endif

// ==== gdc_pkg.sv ====
`default_nettype none
package gdc_pkg;

	// conducting side of one half bridge
	typedef enum logic [1:0] {
		GDC_SIDE_NONE = 2'b00,
		GDC_SIDE_LOW  = 2'b01,
		GDC_SIDE_HIGH = 2'b10
	} gdc_side_t;

	// resolved command pair of one channel
	typedef struct packed {
		logic high_side_command;
		logic low_side_command_n;
	} gdc_cmd_t;

	// comparator pair of one monitored quantity
	typedef struct packed {
		logic below_low;   // quantity under lower threshold (or over shutdown temp)
		logic above_high;  // quantity at upper threshold (or at recovery temp)
	} gdc_cmp_t;

endpackage
`default_nettype wire

// ==== gdc_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gdc_params.svh"
// watches gate outputs against enable and lockout inputs
module gdc_checker
	import gdc_pkg::*;
(
	input wire logic                    clk_i,                 // clock
	input wire logic                    rst_i,                 // reset
	input wire logic                    enable_i,              // enable pin
	input wire logic                    enable_drive_i,        // enable driven
	input wire gdc_cmp_t                supply_cmp_i,          // supply
	input wire gdc_cmp_t [`GDC_NCH-1:0] bootstrap_cmp_i,       // bootstraps
	input wire gdc_cmp_t                gate_supply_cmp_i,     // 12 V
	input wire gdc_cmp_t                logic_supply_cmp_i,    // 5 V
	input wire gdc_cmp_t                temp_cmp_i,            // temperature
	input wire logic [`GDC_NCH-1:0]     high_gate_out_o,       // high gates
	input wire logic [`GDC_NCH-1:0]     low_gate_out_o,        // low gates
	input wire logic                    bootstrap_charge_en_o, // charging
	input wire logic                    gate_supply_en_o       // 12 V on
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// five samples cover the 2ff sync, the lock latch and the gate register
	sequence s_supply; supply_cmp_i.below_low [*5]; endsequence
	sequence s_gate; gate_supply_cmp_i.below_low [*5]; endsequence
	sequence s_logic; logic_supply_cmp_i.below_low [*5]; endsequence
	sequence s_temp; temp_cmp_i.below_low [*5]; endsequence
	a_enable_off: assert property ((!(enable_i && enable_drive_i)) [*4] |->
		!{high_gate_out_o, low_gate_out_o}) else $error("gates on while disabled");
	a_no_overlap: assert property (!(high_gate_out_o & low_gate_out_o))
		else $error("both gates of a channel on");
	a_supply_lock: assert property (s_supply |-> !{high_gate_out_o, low_gate_out_o,
		gate_supply_en_o, bootstrap_charge_en_o}) else $error("supply lock ignored");
	a_bst_lock: assert property (bootstrap_cmp_i[0].below_low [*5] |->
		!high_gate_out_o[0]) else $error("high gate on without bootstrap");
	a_gate_lock: assert property (s_gate |-> !{low_gate_out_o, bootstrap_charge_en_o})
		else $error("gate supply lock ignored");
	a_logic_lock: assert property (s_logic |->
		!{high_gate_out_o, low_gate_out_o, bootstrap_charge_en_o}) else $error("logic lock ignored");
	a_temp_lock: assert property (s_temp |->
		!{high_gate_out_o, low_gate_out_o, bootstrap_charge_en_o}) else $error("hot but driving");
	// a side turning off keeps the other side dark in the sample of the fall and the next two
	for (genvar c = 0; c < `GDC_NCH; c++) begin : g_dead
		a_low_dead: assert property ($fell(high_gate_out_o[c]) |->
			(!low_gate_out_o[c]) [*3]) else $error("low gate inside dead time");
		a_high_dead: assert property ($fell(low_gate_out_o[c]) |->
			(!high_gate_out_o[c]) [*3]) else $error("high gate inside dead time");
	end
endmodule // gdc_checker
bind gdc_top gdc_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
	.enable_drive_i(enable_drive_i), .supply_cmp_i(supply_cmp_i),
	.bootstrap_cmp_i(bootstrap_cmp_i), .gate_supply_cmp_i(gate_supply_cmp_i),
	.logic_supply_cmp_i(logic_supply_cmp_i), .temp_cmp_i(temp_cmp_i),
	.high_gate_out_o(high_gate_out_o), .low_gate_out_o(low_gate_out_o),
	.bootstrap_charge_en_o(bootstrap_charge_en_o), .gate_supply_en_o(gate_supply_en_o));
`default_nettype wire

// ==== gdc_pwm_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// controller pwm timer: charges bootstraps, then complementary switching
module gdc_pwm_model #(
	parameter int CHARGE = 20, // charge cycles, scaled down from milliseconds
	parameter int HALF   = 8   // cycles per half period
) (
	input  wire logic       clk_i,  // clock
	input  wire logic       rst_i,  // reset
	input  wire logic       run_i,  // switching on
	input  wire logic [1:0] gap_i,  // extra off cycles, slow controller
	output logic      [2:0] high_o, // high side commands
	output logic      [2:0] low_n_o // low side commands, low active
);
	int   t;   // cycles since start
	logic sd;  // high half of the period
	logic off; // inside the extra gap
	// time base restarts whenever switching stops
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i)
			t <= 0;
		else if (!run_i)
			t <= 0;
		else
			t <= t + 1;
	end
	// both commands low first, so low sides charge the bootstraps
	always_comb begin
		sd = ((t - CHARGE) % (2 * HALF)) < HALF;
		off = ((t - CHARGE) % HALF) < gap_i;
		{high_o, low_n_o} = 6'h07;
		if (run_i && t < CHARGE)
			{high_o, low_n_o} = 6'h00;
		else if (run_i) begin
			high_o = {sd, !sd, sd} & {3{!off}};
			low_n_o = {sd, !sd, sd} | {3{off}};
		end
	end
endmodule // gdc_pwm_model
`default_nettype wire

// ==== test_three_phase_gate_drive_control.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "gdc_params.svh"
// drives commands, lockout comparators and registers; checks the gates
module test_three_phase_gate_drive_control
	import gdc_pkg::*;
;
	localparam int DEAD = 2; // short dead time keeps the run brief
	// one command setting and the gates it should give
	typedef struct packed {
		logic       e, ed;
		logic [2:0] h, hdv, l, ldv, xh, xl;
	} gdc_row_t;
	// one lockout: status bit, expected gates and supply enables
	typedef struct packed {
		logic [2:0] b, xh, xl;
		logic       xc, xg;
	} gdc_prot_t;
	localparam gdc_row_t ROWS [8] = '{
		'{1'h1, 1'h1, 3'h5, 3'h7, 3'h1, 3'h7, 3'h1, 3'h2},
		'{1'h1, 1'h1, 3'h2, 3'h7, 3'h3, 3'h7, 3'h2, 3'h4},
		'{1'h0, 1'h1, 3'h2, 3'h7, 3'h3, 3'h7, 3'h0, 3'h0},
		'{1'h1, 1'h0, 3'h2, 3'h7, 3'h3, 3'h7, 3'h0, 3'h0},
		'{1'h1, 1'h1, 3'h7, 3'h0, 3'h0, 3'h7, 3'h0, 3'h7},
		'{1'h1, 1'h1, 3'h7, 3'h7, 3'h0, 3'h0, 3'h7, 3'h0},
		'{1'h1, 1'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0},
		'{1'h1, 1'h1, 3'h1, 3'h7, 3'h1, 3'h7, 3'h1, 3'h6}};
	localparam gdc_prot_t PROT [7] = '{
		'{3'h0, 3'h0, 3'h0, 1'h0, 1'h0},
		'{3'h1, 3'h0, 3'h6, 1'h1, 1'h1},
		'{3'h4, 3'h1, 3'h0, 1'h0, 1'h1},
		'{3'h5, 3'h0, 3'h0, 1'h0, 1'h1},
		'{3'h6, 3'h0, 3'h0, 1'h0, 1'h1},
		'{3'h2, 3'h1, 3'h6, 1'h1, 1'h1},
		'{3'h3, 3'h1, 3'h6, 1'h1, 1'h1}};
	logic        clk_i, rst_i, en, en_drv, use_pwm, run, irq, bce, gse;
	logic [2:0]  hs, hd, ln, ld, gh, gl, pwm_h, pwm_ln;
	logic [1:0]  cmp [7]; // supply, bootstrap ch0, 12 V, 5 V, temperature, bootstrap ch1, ch2
	logic [1:0]  gap, s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          fails, samples_checked, i, k, n;
	gdc_top #(.DEAD_CYC(DEAD)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .enable_i(en), .enable_drive_i(en_drv),
		.high_side_command_i(use_pwm ? pwm_h : hs), .high_drive_i(hd),
		.low_side_command_n_i(use_pwm ? pwm_ln : ln), .low_drive_i(ld),
		.supply_cmp_i(cmp[0]), .bootstrap_cmp_i({cmp[6], cmp[5], cmp[1]}),
		.gate_supply_cmp_i(cmp[2]), .logic_supply_cmp_i(cmp[3]), .temp_cmp_i(cmp[4]),
		.high_gate_out_o(gh), .low_gate_out_o(gl), .bootstrap_charge_en_o(bce),
		.gate_supply_en_o(gse), .irq_o(irq), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	gdc_pwm_model u_pwm (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .gap_i(gap),
		.high_o(pwm_h), .low_n_o(pwm_ln));
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic conclude();
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic hang();
		fails++;
		conclude();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("Error %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask
	// bready and rready stay high, so any answer is taken at once
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'h3};
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		if (n == 40) hang();
		else chk(s_axi_bresp, a[1:0] == 2'h0 ? `GDC_RESP_OKAY : `GDC_RESP_SLVERR);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [31:0] x);
		{s_axi_araddr, s_axi_arvalid} <= {a, 1'h1};
		for (n = 0; n < 40; n++) begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		if (n == 40) hang();
		else begin
			chk(s_axi_rdata, x);
			chk(s_axi_rresp, a[1:0] == 2'h0 ? `GDC_RESP_OKAY : `GDC_RESP_SLVERR);
		end
	endtask
	// settle time covers sync, dead time and output register
	task automatic put(input gdc_row_t r);
		{en, en_drv, hs, hd, ln, ld} <= r[19:6];
		repeat (10) @(posedge clk_i);
	endtask
	initial begin
		rst_i = 1'h1;
		{en, en_drv, hs, hd, ln, ld, use_pwm, run, gap} = 18'h0_0000;
		cmp = '{default: 2'h1};
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (4) @(posedge clk_i);
		rd_chk(4'h0, 32'h0000_0001);
		rd_chk(4'hC, 32'h0000_0000);
		// an unmapped word and an unset lane 0 must both leave the enable alone
		axi_wr(4'h1, 32'h0000_0000);
		rd_chk(4'h1, 32'h0000_0000);
		s_axi_wstrb <= 4'h0;
		axi_wr(4'h0, 32'h0000_0000);
		s_axi_wstrb <= 4'hF;
		rd_chk(4'h0, 32'h0000_0001);
		for (i = 0; i < 8; i++) begin
			put(ROWS[i]);
			chk({gh, gl}, {ROWS[i].xh, ROWS[i].xl});
		end
		rd_chk(4'h4, 32'h0000_1880);
		axi_wr(4'h0, 32'h0000_0000);
		repeat (6) @(posedge clk_i);
		chk({gh, gl}, 6'h00);
		axi_wr(4'h0, 32'h0000_0001);
		put(ROWS[4]);
		{hd, ld} <= 6'h38;
		for (k = 0; k < 40 && gl !== 3'h0; k++) @(posedge clk_i);
		for (k = 0; k < 40 && gh !== 3'h7; k++) @(posedge clk_i);
		chk(k, DEAD + 1);
		put(ROWS[7]);
		// each lockout: set, hold between thresholds, release, clear its flag
		for (i = 0; i < 7; i++) begin
			axi_wr(4'hC, i == 4 ? 32'h0000_0000 : 32'h0000_007F);
			cmp[i] <= 2'h2;
			repeat (8) @(posedge clk_i);
			chk({gh, gl, bce, gse}, PROT[i][7:0]);
			chk(irq, i != 4); // the temperature pass runs masked
			rd_chk(4'h8, 32'h0000_0001 << PROT[i].b);
			cmp[i] <= 2'h0;
			repeat (8) @(posedge clk_i);
			chk({gh, gl, bce, gse}, PROT[i][7:0]);
			cmp[i] <= 2'h1;
			repeat (12) @(posedge clk_i);
			chk({gh, gl, bce, gse}, 8'h3B);
			axi_wr(4'h8, 32'h0000_0001 << PROT[i].b);
			chk(irq, 1'h0);
		end
		rst_i <= 1'h1;
		@(posedge clk_i);
		chk({gh, gl, bce, gse}, 8'h00);
		rst_i <= 1'h0;
		repeat (12) @(posedge clk_i);
		chk({gh, gl, bce, gse}, 8'h3B);
		{use_pwm, run} <= 2'h3;
		repeat (10) @(posedge clk_i);
		chk(gl, 3'h7);
		repeat (100) @(posedge clk_i);
		gap <= 2'h2;
		repeat (100) @(posedge clk_i);
		run <= 1'h0;
		repeat (10) @(posedge clk_i);
		chk({gh, gl}, 6'h00);
		conclude();
	end
endmodule // test_three_phase_gate_drive_control
`default_nettype wire
